// File: design/lp_int_detect.sv
/*
  Comparator change detector: synchronises the four comparator levels,
  snapshots them before low power, and flags any enabled change.
  Assumes comparator inputs are asynchronous to the core clock.
*/
`timescale 1ns/1ps
module lp_int_detect (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] cmp_raw_i,
  lp_if.detect lp
);
  import ulpi_lp_pkg::*;

  logic [3:0] cmp_meta;
  logic [3:0] cmp_sync;
  logic [3:0] base;
  logic [3:0] fired;

  // two-stage synchroniser, first stage read by the second only
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmp_meta <= 4'h0;
      cmp_sync <= 4'h0;
    end else begin
      cmp_meta <= cmp_raw_i;
      cmp_sync <= cmp_meta;
    end
  end

  // snapshot taken every cycle until dir rises, then frozen
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      base <= 4'h0;
    end else if (!lp.lp_active) begin
      base <= cmp_sync;
    end
  end

  // sticky per-source flags; leaving low power clears them
  for (genvar i = 0; i < 4; i++) begin : g_src
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        fired[i] <= 1'b0;
      end else if (!lp.lp_active) begin
        fired[i] <= 1'b0;
      end else if ((lp.en_rise[i] && cmp_sync[i] && !base[i]) ||
                   (lp.en_fall[i] && !cmp_sync[i] && base[i])) begin
        fired[i] <= 1'b1;
      end
    end
  end

  // interrupt level and comparator power enables
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lp.int_level <= 1'b0;
      lp.vbus_on <= 1'b1;
      lp.sess_end_on <= 1'b1;
    end else begin
      lp.int_level <= |fired;
      // the vbus or session-end comparator with no edge enabled at all is powered off
      lp.vbus_on <= lp.en_rise[CMP_VBUS] | lp.en_fall[CMP_VBUS];
      lp.sess_end_on <= lp.en_rise[CMP_SESS_END] |
                        lp.en_fall[CMP_SESS_END];
    end
  end

  assign lp.cmp_level = cmp_sync;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  chk_vbus_power_off: assert property (
    (!lp.en_rise[CMP_VBUS] && !lp.en_fall[CMP_VBUS]) |=> !lp.vbus_on)
    else $error("vbus comparator left powered with no enable");

  chk_change_fires: assert property (
    (lp.lp_active && |((lp.en_rise & cmp_sync & ~base) |
     (lp.en_fall & ~cmp_sync & base))) |=> ##1 lp.int_level)
    else $error("enabled comparator change did not raise interrupt");

endmodule : lp_int_detect

// File: design/ulpi_low_power_control.sv
/*
  ULPI transceiver low-power control: suspend entry after the suspend
  bit is cleared, output clock stop, low-power data bus mapping, wake on
  stp with start-up delay, false-resume return, and the stp pull-up.
  Assumes stp, dp, dm and comparator pins are asynchronous and the
  register port is driven synchronously by the register-write front end.
*/
// Decided for this implementation: the address map and the strobed register port.
// Notes on behaviour
// - raise dir, five clock edges, stop, power down
// - data bit 3 shows unmasked interrupt
// - enabled comparator change raises interrupt line
// - bus driven without clock while suspended
// - stp wakes device into start-up procedure
// - after start-up: clock on, dir low, suspend set
// - early stp release returns to low power
// - one turnaround clock after each dir change
// - stp pull-up on, disable bit 7 clears it
// - pull-up off while hardware reset held low
// - stp high in suspend always wakes device
// - comparator off when both edge enables clear (only vbus and session end have power enables)
`timescale 1ns/1ps
module ulpi_low_power_control (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic stp_i,
  input wire logic dp_i,
  input wire logic dm_i,
  input wire logic [3:0] cmp_raw_i,
  output logic output_clock_pin_o,
  output logic dir_o,
  output logic [7:0] data_o,
  output logic data_oe_b_o,
  output logic stp_pullup_en_o,
  output logic vbus_valid_comparator_on_o,
  output logic session_end_comparator_on_o,
  output logic low_current_o,
  output logic [1:0] line_driver_op_field_o
);
  import ulpi_lp_pkg::*;

  lp_if lp ();

  lp_state_t state;
  logic [7:0] func_ctrl;
  logic [7:0] intf_ctrl;
  logic [7:0] int_en_rise;
  logic [7:0] int_en_fall;
  logic stp_meta;
  logic stp_s;
  logic [1:0] line_meta;
  logic [1:0] line_s;
  logic [1:0] div_cnt;
  logic clk_en;
  logic clk_rise;
  logic [2:0] edge_cnt;
  logic [15:0] tmr;
  logic exit_done;
  logic [3:0] rises_dir;

  lp_int_detect u_detect (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .cmp_raw_i(cmp_raw_i),
    .lp(lp)
  );

  // pins from the link and the line pass two flops before use
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stp_meta <= 1'b0;
      stp_s <= 1'b0;
      line_meta <= 2'h0;
      line_s <= 2'h0;
    end else begin
      stp_meta <= stp_i;
      stp_s <= stp_meta;
      line_meta <= {dm_i, dp_i};
      line_s <= line_meta;
    end
  end

  // output clock runs in every state except S_LOW and S_START
  assign clk_en = (state != S_LOW) && (state != S_START);
  assign clk_rise = clk_en && (div_cnt == CLK_HALF_LAST) &&
                    !output_clock_pin_o;
  assign exit_done = (state == S_RESTART) && stp_s && clk_rise &&
                     (edge_cnt == RESTART_EDGES - 3'h1);

  // clock divider; stopping it parks the pin low
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt <= 2'h0;
      output_clock_pin_o <= 1'b0;
    end else if (!clk_en) begin
      div_cnt <= 2'h0;
      output_clock_pin_o <= 1'b0;
    end else if (div_cnt == CLK_HALF_LAST) begin
      div_cnt <= 2'h0;
      output_clock_pin_o <= !output_clock_pin_o;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  // suspend sequencing: entry, power-down, wake, false resume, exit
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= S_SYNC;
      edge_cnt <= 3'h0;
      tmr <= 16'h0000;
      dir_o <= 1'b0;
      data_oe_b_o <= 1'b1;
      low_current_o <= 1'b0;
    end else begin
      unique case (state)
        S_SYNC: begin
          // the link owns the bus here; entry starts on the cleared bit
          if (!func_ctrl[SUSPEND_BIT]) begin
            state <= S_ENTER;
            edge_cnt <= 3'h0;
            dir_o <= 1'b1;
          end
        end
        S_ENTER: begin
          // first clock rise after dir ends the turnaround
          if (clk_rise) begin
            data_oe_b_o <= 1'b0;
            if (edge_cnt != MIN_STOP_EDGES) begin
              edge_cnt <= edge_cnt + 3'h1;
            end
          end
          // stop only once the clock sits low after five rises
          if (edge_cnt == MIN_STOP_EDGES && !output_clock_pin_o) begin
            state <= S_LOW;
            low_current_o <= 1'b1;
            data_oe_b_o <= 1'b0;
          end
        end
        S_LOW: begin
          // stp from the link or the pull-up both wake the device
          if (stp_s) begin
            state <= S_START;
            tmr <= 16'h0000;
            low_current_o <= 1'b0;
          end
        end
        S_START: begin
          if (!stp_s) begin
            state <= S_LOW;
            low_current_o <= 1'b1;
          end else if (tmr == START_LAST) begin
            state <= S_RESTART;
            edge_cnt <= 3'h0;
          end else begin
            tmr <= tmr + 16'h0001;
          end
        end
        S_RESTART: begin
          // the clock is running again; dir still held high
          if (!stp_s) begin
            state <= S_ENTER;
            edge_cnt <= 3'h0;
          end else if (exit_done) begin
            state <= S_WAIT_STP;
            dir_o <= 1'b0;
            data_oe_b_o <= 1'b1;
          end else if (clk_rise) begin
            edge_cnt <= edge_cnt + 3'h1;
          end
        end
        S_WAIT_STP: begin
          // link releases stp when ready; synchronous mode resumes
          if (!stp_s) begin
            state <= S_SYNC;
          end
        end
      endcase
    end
  end

  // low-power bus image; reflects pins with no output clock running
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_o <= 8'h00;
    end else if (state == S_LOW || state == S_START) begin
      data_o <= {4'h0, lp.int_level, 1'b0, line_s[1], line_s[0]};
    end else begin
      data_o <= 8'h00;
    end
  end

  // register writes; the exit sets the suspend bit and wins a clash
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      func_ctrl <= FUNC_CTRL_RESET;
      intf_ctrl <= INTF_CTRL_RESET;
      int_en_rise <= INT_EN_RESET;
      int_en_fall <= INT_EN_RESET;
    end else begin
      if (reg_wr_i) begin
        unique case (reg_addr_i)
          ADDR_FUNC_CTRL: func_ctrl <= reg_wdata_i;
          ADDR_INTF_CTRL: intf_ctrl <= reg_wdata_i;
          ADDR_INT_EN_RISE: int_en_rise <= reg_wdata_i;
          ADDR_INT_EN_FALL: int_en_fall <= reg_wdata_i;
          default: ;
        endcase
      end
      if (exit_done) begin
        func_ctrl[SUSPEND_BIT] <= 1'b1;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_FUNC_CTRL: reg_rdata_o <= func_ctrl;
        ADDR_INTF_CTRL: reg_rdata_o <= intf_ctrl;
        ADDR_INT_EN_RISE: reg_rdata_o <= int_en_rise;
        ADDR_INT_EN_FALL: reg_rdata_o <= int_en_fall;
        ADDR_LP_STATUS: reg_rdata_o <= {lp.cmp_level, clk_en,
                                        lp.int_level, low_current_o, dir_o};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // pull-up held off through reset, then follows the disable bit
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stp_pullup_en_o <= 1'b0;
      vbus_valid_comparator_on_o <= 1'b1;
      session_end_comparator_on_o <= 1'b1;
      line_driver_op_field_o <= 2'h0;
    end else begin
      stp_pullup_en_o <= !intf_ctrl[PULLUP_DIS_BIT];
      vbus_valid_comparator_on_o <= lp.vbus_on;
      session_end_comparator_on_o <= lp.sess_end_on;
      line_driver_op_field_o <= func_ctrl[OP_FIELD_LSB +: 2];
    end
  end

  // detector sees dir as the low-power window and the edge enables
  assign lp.lp_active = dir_o;
  assign lp.en_rise = int_en_rise[EN_FIELD_LSB +: 4];
  assign lp.en_fall = int_en_fall[EN_FIELD_LSB +: 4];

  // helper: clock rises seen since dir went high, saturating
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rises_dir <= 4'h0;
    end else if (!dir_o) begin
      rises_dir <= 4'h0;
    end else if (clk_rise && rises_dir != 4'hF) begin
      rises_dir <= rises_dir + 4'h1;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_wake;
    state == S_LOW && stp_s ##1 state == S_START;
  endsequence

  sequence s_exit;
    state == S_RESTART && exit_done ##1 !dir_o && data_oe_b_o;
  endsequence

  chk_entry_raises_dir: assert property (
    (state == S_SYNC && !func_ctrl[SUSPEND_BIT]) |=> dir_o)
    else $error("dir not raised after suspend bit cleared");

  chk_five_clock_edges: assert property (
    $rose(low_current_o) |-> rises_dir >= 4'h5 && !output_clock_pin_o)
    else $error("clock stopped before five rising edges");

  chk_lp_bus_map: assert property (
    (low_current_o && $past(low_current_o)) |->
      data_o[7:4] == 4'h0 && !data_o[2] && !data_oe_b_o &&
      data_o[1:0] == $past(line_s))
    else $error("low-power bus mapping wrong");

  chk_int_on_bus: assert property (
    (low_current_o && lp.int_level) |=> data_o[3])
    else $error("interrupt not shown on data bit 3");

  chk_clock_held_low: assert property (
    low_current_o |-> !output_clock_pin_o)
    else $error("output clock runs during low power");

  chk_stp_wakes: assert property (
    (state == S_LOW && stp_s) |-> s_wake)
    else $error("stp high did not start wake-up");

  chk_false_resume: assert property (
    (state == S_START && !stp_s) |=> state == S_LOW && low_current_o)
    else $error("early stp release did not return to low power");

  chk_startup_time: assert property (
    s_wake ##0 stp_s [*4] |-> ##[0:300] state != S_START)
    else $error("start-up did not finish in time");

  chk_exit_order: assert property (
    exit_done |-> s_exit ##0 (output_clock_pin_o && func_ctrl[SUSPEND_BIT]))
    else $error("exit did not release dir and set suspend bit");

  chk_dir_held: assert property (
    (state == S_LOW || state == S_START) |-> dir_o)
    else $error("dir dropped during low power");

  chk_pullup_disable: assert property (
    (reg_wr_i && reg_addr_i == ADDR_INTF_CTRL &&
     reg_wdata_i[PULLUP_DIS_BIT]) |=> ##1 !stp_pullup_en_o)
    else $error("pull-up stayed on after disable written");

endmodule : ulpi_low_power_control

// File: pkg/lp_if.sv
/*
  Carrier between the low-power controller and its comparator interrupt
  detector. Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface lp_if;
  logic lp_active;
  logic [3:0] en_rise;
  logic [3:0] en_fall;
  logic [3:0] cmp_level;
  logic int_level;
  logic vbus_on;
  logic sess_end_on;

  modport core (
    output lp_active,
    output en_rise,
    output en_fall,
    input cmp_level,
    input int_level,
    input vbus_on,
    input sess_end_on
  );

  modport detect (
    input lp_active,
    input en_rise,
    input en_fall,
    output cmp_level,
    output int_level,
    output vbus_on,
    output sess_end_on
  );
endinterface : lp_if

// File: pkg/ulpi_lp_pkg.sv
/*
  Shared constants for the ULPI low-power control block: register
  addresses, field positions, reset values, timing counts and states.
  Assumes a 200 MHz core clock driving every flip-flop of the block.
*/
package ulpi_lp_pkg;

  // core clock and derived counts
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_START_NS = 1000; // start-up time, plain default
  localparam int START_CYC_INT = (T_START_NS * 1000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam logic [15:0] START_CYCLES = 16'(START_CYC_INT);
  localparam logic [15:0] START_LAST = 16'(START_CYC_INT - 1);

  // output clock divider: last count of each two-core-cycle half period
  localparam logic [1:0] CLK_HALF_LAST = 2'h1;
  // rising edges of the output clock before it is held low
  localparam logic [2:0] MIN_STOP_EDGES = 3'h5;
  // rising edges of the restarted clock before dir falls
  localparam logic [2:0] RESTART_EDGES = 3'h1;

  // register addresses
  localparam logic [5:0] ADDR_FUNC_CTRL = 6'h04;
  localparam logic [5:0] ADDR_INTF_CTRL = 6'h07;
  localparam logic [5:0] ADDR_INT_EN_RISE = 6'h0D;
  localparam logic [5:0] ADDR_INT_EN_FALL = 6'h10;
  localparam logic [5:0] ADDR_LP_STATUS = 6'h30;

  // field positions
  localparam int SUSPEND_BIT = 6;
  localparam int OP_FIELD_LSB = 3;
  localparam int PULLUP_DIS_BIT = 7;
  localparam int EN_FIELD_LSB = 1;

  // reset values
  localparam logic [7:0] FUNC_CTRL_RESET = 8'h41;
  localparam logic [7:0] INTF_CTRL_RESET = 8'h00;
  localparam logic [7:0] INT_EN_RESET = 8'h1F;

  // comparator index inside the four-bit comparator vector
  localparam int CMP_VBUS = 0;
  localparam int CMP_SESS_VLD = 1;
  localparam int CMP_SESS_END = 2;
  localparam int CMP_ID_GND = 3;

  typedef enum logic [2:0] {
    S_SYNC,
    S_ENTER,
    S_LOW,
    S_START,
    S_RESTART,
    S_WAIT_STP
  } lp_state_t;

endpackage : ulpi_lp_pkg

// File: verif/tb_top.sv
/*
  Self-checking bench for the ULPI low-power control: registers, entry,
  low-power bus, interrupts, wake, false resume and warm reset.
  Assumes the package, design files and link model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import ulpi_lp_pkg::*;
  logic mclk = 1'b0;
  logic lclk = 1'b0;
  logic rst_b = 1'b0;
  logic link_rst_b = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic dp = 1'b1;
  logic dm = 1'b0;
  logic [3:0] cmp = 4'h0;
  logic wake = 1'b0;
  logic early = 1'b0;
  logic [7:0] rdata;
  logic [7:0] data;
  logic [1:0] op;
  logic stp, oclk, dir, oe_b, pu_en, vbus_on, se_on, low_cur;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  int e, h, r;

  ulpi_low_power_control uut (
    .mclk_i(mclk), .rst_b_i(rst_b), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .stp_i(stp), .dp_i(dp), .dm_i(dm),
    .cmp_raw_i(cmp), .output_clock_pin_o(oclk), .dir_o(dir),
    .data_o(data), .data_oe_b_o(oe_b), .stp_pullup_en_o(pu_en),
    .vbus_valid_comparator_on_o(vbus_on),
    .session_end_comparator_on_o(se_on), .low_current_o(low_cur),
    .line_driver_op_field_o(op)
  );

  ulpi_link_model link (
    .lclk_i(lclk), .link_rst_b_i(link_rst_b), .dir_i(dir),
    .wake_i(wake), .early_i(early), .pullup_en_i(pu_en), .stp_o(stp)
  );

  // core clock at 200 MHz, link clock at 64 ns with its own phase
  initial forever #2.5 mclk = ~mclk;
  initial begin
    #7;
    forever #32 lclk = ~lclk;
  end

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      $display("wrong value at %0t: run timed out", $time);
      complete_run();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string m);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s seen %h want %h", $time, m,
               seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_read

  task automatic ticks(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : ticks

  // clear the suspend bit, count clock rises until power-down
  task automatic enter_lp(output int edges);
    logic prev;
    edges = 0;
    prev = 1'b0;
    reg_write(ADDR_FUNC_CTRL, 8'h49);
    reg_write(ADDR_FUNC_CTRL, 8'h09);
    for (int n = 0; n < 400 && low_cur !== 1'b1; n++) begin
      ticks(1);
      if (dir === 1'b1 && oclk === 1'b1 && prev === 1'b0) edges++;
      prev = oclk;
    end
    check(low_cur, 1'b1, "powered down");
    check(dir, 1'b1, "dir in low power");
    check(oclk, 1'b0, "clock held low");
    check(op, 2'h1, "line driver field");
  endtask : enter_lp

  // wake through the link, then wait for it to drop stp again
  task automatic exit_lp(output int held, output int rises);
    logic prev;
    held = 0;
    rises = 0;
    prev = oclk;
    @(posedge mclk);
    wake <= 1'b1;
    for (int n = 0; n < 2000 && dir !== 1'b0; n++) begin
      ticks(1);
      if (stp === 1'b1) held++;
      if (oclk === 1'b1 && prev === 1'b0) rises++;
      prev = oclk;
    end
    check(dir, 1'b0, "dir after wake");
    check(oe_b, 1'b1, "bus released");
    @(posedge mclk);
    wake <= 1'b0;
    for (int n = 0; n < 100 && stp !== 1'b0; n++) ticks(1);
    ticks(6);
  endtask : exit_lp

  task automatic t_reset();
    logic [7:0] d;
    ticks(3);
    check(pu_en, 1'b1, "pull-up after reset");
    check({vbus_on, se_on, dir, oe_b}, 4'hD, "reset outputs");
    check(op, 2'h0, "op field");
    reg_read(ADDR_FUNC_CTRL, d);
    check(d, FUNC_CTRL_RESET, "func ctrl");
    reg_read(ADDR_INT_EN_FALL, d);
    check(d, INT_EN_RESET, "fall enables");
    reg_read(6'h3F, d);
    check(d, 8'h00, "unmapped read");
    reg_write(ADDR_INTF_CTRL, 8'h80);
    ticks(2);
    check(pu_en, 1'b0, "pull-up disabled");
    reg_write(ADDR_INTF_CTRL, INTF_CTRL_RESET);
    ticks(2);
    check(pu_en, 1'b1, "pull-up back on");
    $display("test reset and pull-up done");
  endtask : t_reset

  task automatic t_power();
    logic [7:0] rise[3] = '{8'h1D, 8'h1D, 8'h17};
    logic [7:0] fall[3] = '{8'h1D, 8'h1F, 8'h17};
    logic [1:0] exp[3] = '{2'h1, 2'h3, 2'h2};
    for (int i = 0; i < 3; i++) begin
      reg_write(ADDR_INT_EN_RISE, rise[i]);
      reg_write(ADDR_INT_EN_FALL, fall[i]);
      ticks(2);
      check({vbus_on, se_on}, exp[i], "cmp power");
    end
    reg_write(ADDR_INT_EN_RISE, INT_EN_RESET);
    reg_write(ADDR_INT_EN_FALL, INT_EN_RESET);
    $display("test comparator power done");
  endtask : t_power

  task automatic t_enter_map();
    logic [7:0] d;
    enter_lp(e);
    check(e >= 5, 1'b1, "clock rises before stop");
    reg_read(ADDR_LP_STATUS, d);
    check(d, 8'h03, "status in low power");
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      dp <= i[0];
      dm <= i[1];
      ticks(6);
      check(data, {6'h00, i[1], i[0]}, "low-power bus");
      check({oe_b, oclk}, 2'h0, "driven with clock stopped");
    end
    exit_lp(h, r);
    check(h >= START_CYCLES, 1'b1, "start-up time");
    check(h <= START_CYCLES + 10, 1'b1, "start-up bound");
    check(r >= 1, 1'b1, "clock before dir falls");
    reg_read(ADDR_FUNC_CTRL, d);
    check(d, 8'h49, "suspend bit set");
    $display("test entry, bus map and exit done");
  endtask : t_enter_map

  task automatic t_int();
    enter_lp(e);
    @(posedge mclk);
    cmp <= 4'h1;
    ticks(6);
    check(data[3], 1'b1, "enabled change");
    exit_lp(h, r);
    reg_write(ADDR_INT_EN_RISE, 8'h0F);
    reg_write(ADDR_INT_EN_FALL, 8'h0F);
    enter_lp(e);
    @(posedge mclk);
    cmp <= 4'h9;
    ticks(6);
    check(data[3], 1'b0, "masked change");
    exit_lp(h, r);
    reg_write(ADDR_INT_EN_RISE, INT_EN_RESET);
    reg_write(ADDR_INT_EN_FALL, INT_EN_RESET);
    $display("test interrupt done");
  endtask : t_int

  task automatic t_false();
    int lows;
    lows = 0;
    enter_lp(e);
    @(posedge mclk);
    early <= 1'b1;
    wake <= 1'b1;
    for (int n = 0; n < 100 && stp !== 1'b1; n++) ticks(1);
    @(posedge mclk);
    wake <= 1'b0;
    for (int n = 0; n < 400; n++) begin
      ticks(1);
      if (dir !== 1'b1) lows++;
    end
    check(lows, 0, "dir kept high");
    check(low_cur, 1'b1, "back in low power");
    @(posedge mclk);
    early <= 1'b0;
    exit_lp(h, r);
    $display("test false resume done");
  endtask : t_false

  // link reset floats stp; the pull-up alone must wake the device
  task automatic t_warm();
    logic [7:0] d;
    enter_lp(e);
    @(posedge mclk);
    link_rst_b <= 1'b0;
    for (int n = 0; n < 2000 && dir !== 1'b0; n++) ticks(1);
    check({dir, oe_b}, 2'h1, "woken by pull-up");
    @(posedge mclk);
    link_rst_b <= 1'b1;
    ticks(30);
    reg_read(ADDR_FUNC_CTRL, d);
    check(d, 8'h49, "suspend bit after warm wake");
    $display("test warm reset done");
  endtask : t_warm

  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    #1;
    check(pu_en, 1'b0, "pull-up in reset");
    @(posedge mclk);
    rst_b <= 1'b1;
    link_rst_b <= 1'b1;
    t_reset();
    t_power();
    t_enter_map();
    t_int();
    t_false();
    t_warm();
    complete_run();
  end
endmodule : tb_top

// File: verif/ulpi_link_model.sv
/*
  Link controller model for the far side of the low-power port: drives
  stp on its own clock and lets it float to the pull-up while in reset.
  Assumes the bench supplies the link clock and the wake requests.
*/
`timescale 1ns/1ps
module ulpi_link_model (
  input wire logic lclk_i,
  input wire logic link_rst_b_i,
  input wire logic dir_i,
  input wire logic wake_i,
  input wire logic early_i,
  input wire logic pullup_en_i,
  output logic stp_o
);
  logic stp_q;
  logic last = 1'b0;

  // stp request, held until the device hands the bus back, or with early_i set only until wake_i falls
  always_ff @(posedge lclk_i or negedge link_rst_b_i) begin
    if (!link_rst_b_i) begin
      stp_q <= 1'b0;
    end else if (wake_i && dir_i) begin
      stp_q <= 1'b1;
    end else if (!dir_i || early_i) begin
      stp_q <= 1'b0;
    end
  end

  // remember the driven level so a floating pin shows its inverse
  always @(posedge lclk_i) begin
    if (link_rst_b_i) begin
      last <= stp_q;
    end
  end

  // output floats in reset: pull-up wins, else never the old level
  assign stp_o = link_rst_b_i ? stp_q :
                 (pullup_en_i ? 1'b1 : ~last);
endmodule : ulpi_link_model
